// *** core/ioxc_intercept.v ***
// Intercept check for guest port I/O, model register access and exceptions.
// Assumes a core issuing one request at a time and a memory answering bit reads.
// Functional notes
// RULE1: Port map is a 64K+3 bit linear array, 12 KB, 4 KB aligned.
// RULE2: Launch drops the low 12 bits of both map bases.
// RULE3: Map last byte at or above max address gives invalid-state exit.
// RULE4: Port map bit n set means port n exits.
// RULE5: Multi-byte port access exits if any touched byte bit is set.
// RULE6: Port faults from v86, privilege or task bitmap precede intercept.
// RULE7: Port exit word holds port, segment and address width flags.
// RULE8: Port exit word holds operand size, iterated and block flags.
// RULE9: Bit 0 is direction, in is 1; bits 15:13 and 1 read zero.
// RULE10: Second exit word holds next instruction pointer on port exit.
// RULE11: Block output reports effective segment; block input reports zero.
// RULE12: Model map has two bits per register, low read, high write.
// RULE13: Three map slices cover three register ranges; last slice reserved.
// RULE14: Registers outside mapped ranges always exit when enabled.
// RULE15: Model register access never exits when enable clear.
// RULE16: Common faults first, then map check, then register faults.
// RULE17: Model exit word is 0 for read, 1 for write.
// RULE18: Exception exit word carries the error code when defined.
// RULE19: Breakpoint, overflow and bound save own pointer, others stack value.
// RULE20: External and software interrupts skip exception intercepts.
// RULE21: Nested exception checked before merge; merged result checked again.
// RULE22: Debug exceptions update debug registers before the intercept.
// RULE23: Debug fault saves own pointer, trap next; single-byte debug exempt.
// RULE24: Ports near the top use the three extra map bits, no wrap.
`timescale 1ns/1ps
`default_nettype none
`include "ioxc_consts.vh"
module ioxc_intercept (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:2] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Request from core
  input wire req_valid_i,
  input wire [1:0] req_kind_i,
  input wire [15:0] req_port_i,
  input wire [2:0] req_size_i,
  input wire [2:0] req_addr_width_i,
  input wire [2:0] req_seg_i,
  input wire req_in_i,
  input wire req_rep_i,
  input wire req_str_i,
  input wire [31:0] req_msr_i,
  input wire req_msr_write_i,
  input wire req_pre_fault_i,
  input wire [63:0] req_next_ip_i,
  input wire [63:0] req_own_ip_i,
  input wire [63:0] req_frame_ip_i,
  input wire [4:0] req_vec_i,
  input wire req_has_err_i,
  input wire [31:0] req_err_i,
  input wire req_is_intr_i,
  input wire req_debug_trap_i,
  input wire req_single_byte_dbg_i,
  input wire req_merged_i,
  output wire req_ready_o,
  // Result to core
  output reg done_o,
  output reg exit_o,
  output reg post_faults_o,
  output reg debug_regs_update_o,
  // Bitmap memory bit read
  output reg mem_req_o,
  output reg [51:0] mem_addr_o,
  output reg [2:0] mem_bit_o,
  input wire mem_ack_i,
  input wire mem_bit_i
);

  localparam [1:0] KIND_PORT = 2'h0;
  localparam [1:0] KIND_MODEL = 2'h1;
  localparam [1:0] KIND_EXC = 2'h2;
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_FETCH = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_DONE = 3'h3;

  reg [31:0] ctrl_ff;
  reg [31:0] port_base_lo_ff, port_base_hi_ff, model_base_lo_ff, model_base_hi_ff;
  reg [31:0] maxpa_ff, excmask_ff;
  reg [51:0] port_base_ff, model_base_ff;
  reg [11:0] exit_code_ff;
  reg [31:0] info1_ff;
  reg [63:0] info2_ff;
  reg [31:0] pend_ff;
  reg [31:0] prior_ff;
  reg [2:0] state_ff;
  reg [2:0] cnt_ff, nbytes_ff;
  reg [16:0] bitno_ff;
  reg hit_ff, is_port_ff;
  reg ack_ff;

  wire bus_req = wb_cyc_i & wb_stb_i;
  wire [51:0] nxt_port_base = {port_base_hi_ff[19:0], port_base_lo_ff[31:12], 12'h000};
  wire [51:0] nxt_model_base = {model_base_hi_ff[19:0], model_base_lo_ff[31:12], 12'h000};
  wire [51:0] maxpa = {maxpa_ff[19:0], 32'h0000_0000};
  wire port_en = ctrl_ff[`IOXC_CTRL_PORT_EN];
  wire model_en = ctrl_ff[`IOXC_CTRL_MODEL_EN];

  assign wb_ack_o = ack_ff;
  assign req_ready_o = (state_ff == ST_IDLE);

  // Model register slice decode
  reg msr_mapped;
  reg [1:0] msr_slice;
  always @* begin
    msr_mapped = 1'b1;
    msr_slice = 2'h0;
    // RULE13 slice select
    if (req_msr_i[31:13] == 19'h0_0000) begin
      msr_slice = 2'h0;
    end else if (req_msr_i[31:13] == `IOXC_MSR_HI_MID) begin
      msr_slice = `IOXC_MAP_OFS_MID;
    end else if (req_msr_i[31:13] == `IOXC_MSR_HI_TOP) begin
      msr_slice = `IOXC_MAP_OFS_TOP;
    end else begin
      msr_mapped = 1'b0;
    end
  end
  // RULE12 two bits per register
  wire [16:0] msr_bitno = {1'b0, msr_slice, req_msr_i[12:0], req_msr_write_i};
  wire [2:0] port_bytes = req_size_i[2] ? 3'h4 : (req_size_i[1] ? 3'h2 : 3'h1);

  // Bus writes and reads
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      wb_dat_o <= `IOXC_RST_WORD;
      ctrl_ff <= `IOXC_RST_WORD;
      port_base_lo_ff <= `IOXC_RST_WORD;
      port_base_hi_ff <= `IOXC_RST_WORD;
      model_base_lo_ff <= `IOXC_RST_WORD;
      model_base_hi_ff <= `IOXC_RST_WORD;
      maxpa_ff <= `IOXC_RST_MAXPA;
      excmask_ff <= `IOXC_RST_WORD;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (bus_req & ~ack_ff & wb_we_i & (&wb_sel_i)) begin
        case (wb_adr_i)
          `IOXC_REG_CTRL: ctrl_ff <= wb_dat_i & 32'h0000_0003;
          `IOXC_REG_PORT_BASE_LO: port_base_lo_ff <= wb_dat_i;
          `IOXC_REG_PORT_BASE_HI: port_base_hi_ff <= wb_dat_i;
          `IOXC_REG_MODEL_BASE_LO: model_base_lo_ff <= wb_dat_i;
          `IOXC_REG_MODEL_BASE_HI: model_base_hi_ff <= wb_dat_i;
          `IOXC_REG_MAXPA: maxpa_ff <= wb_dat_i;
          `IOXC_REG_EXCMASK: excmask_ff <= wb_dat_i;
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
      case (wb_adr_i)
        `IOXC_REG_CTRL: wb_dat_o <= ctrl_ff;
        `IOXC_REG_PORT_BASE_LO: wb_dat_o <= port_base_lo_ff;
        `IOXC_REG_PORT_BASE_HI: wb_dat_o <= port_base_hi_ff;
        `IOXC_REG_MODEL_BASE_LO: wb_dat_o <= model_base_lo_ff;
        `IOXC_REG_MODEL_BASE_HI: wb_dat_o <= model_base_hi_ff;
        `IOXC_REG_MAXPA: wb_dat_o <= maxpa_ff;
        `IOXC_REG_EXCMASK: wb_dat_o <= excmask_ff;
        `IOXC_REG_STATUS: wb_dat_o <= {29'h0, state_ff};
        `IOXC_REG_CODE: wb_dat_o <= {20'h0_0000, exit_code_ff};
        `IOXC_REG_INFO1: wb_dat_o <= info1_ff;
        `IOXC_REG_INFO2_LO: wb_dat_o <= info2_ff[31:0];
        `IOXC_REG_INFO2_HI: wb_dat_o <= info2_ff[63:32];
        `IOXC_REG_PEND: wb_dat_o <= pend_ff;
        default: wb_dat_o <= `IOXC_RST_WORD;
      endcase
    end
  end

  // Port exit word
  wire [31:0] port_info;
  // RULE7 port, segment, address width
  // RULE8 size, iterated, block
  // RULE9 direction, reserved zero
  // RULE11 block input uses extra segment
  assign port_info = {req_port_i, 3'h0,
    (req_str_i & req_in_i) ? `IOXC_SEG_EXTRA : req_seg_i,
    req_addr_width_i, req_size_i, req_rep_i, req_str_i, 1'b0, req_in_i};

  // Check sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      port_base_ff <= 52'h0;
      model_base_ff <= 52'h0;
      exit_code_ff <= `IOXC_EXIT_NONE;
      info1_ff <= `IOXC_RST_WORD;
      info2_ff <= 64'h0;
      pend_ff <= `IOXC_RST_WORD;
      prior_ff <= `IOXC_RST_WORD;
      cnt_ff <= 3'h0;
      nbytes_ff <= 3'h0;
      bitno_ff <= 17'h0;
      hit_ff <= 1'b0;
      is_port_ff <= 1'b0;
      done_o <= 1'b0;
      exit_o <= 1'b0;
      post_faults_o <= 1'b0;
      debug_regs_update_o <= 1'b0;
      mem_req_o <= 1'b0;
      mem_addr_o <= 52'h0;
      mem_bit_o <= 3'h0;
    end else begin
      done_o <= 1'b0;
      debug_regs_update_o <= 1'b0;
      // RULE2 launch drops low 12 bits
      // RULE3 map end at or past max address
      if (bus_req & ~ack_ff & wb_we_i & (wb_adr_i == `IOXC_REG_CTRL) &
          wb_dat_i[`IOXC_CTRL_LAUNCH]) begin
        port_base_ff <= nxt_port_base;
        model_base_ff <= nxt_model_base;
        if ((nxt_port_base + `IOXC_PORT_MAP_LAST >= maxpa) ||
            (nxt_model_base + `IOXC_MODEL_MAP_LAST >= maxpa)) begin
          exit_code_ff <= `IOXC_EXIT_INVALID;
        end else begin
          exit_code_ff <= `IOXC_EXIT_NONE;
        end
      end
      case (state_ff)
        ST_IDLE: begin
          if (req_valid_i) begin
            hit_ff <= 1'b0;
            exit_o <= 1'b0;
            post_faults_o <= 1'b0;
            case (req_kind_i)
              KIND_PORT: begin
                is_port_ff <= 1'b1;
                // RULE6 early faults win
                if (req_pre_fault_i | ~port_en) begin
                  state_ff <= ST_DONE;
                  post_faults_o <= ~req_pre_fault_i;
                end else begin
                  // RULE24 extra bits avoid wrap
                  bitno_ff <= {1'b0, req_port_i};
                  post_faults_o <= 1'b1;
                  nbytes_ff <= port_bytes;
                  cnt_ff <= 3'h0;
                  state_ff <= ST_FETCH;
                end
                info1_ff <= port_info;
                info2_ff <= req_next_ip_i;
              end
              KIND_MODEL: begin
                is_port_ff <= 1'b0;
                // RULE16 common faults first
                // RULE15 no exit when disabled
                if (req_pre_fault_i | ~model_en) begin
                  state_ff <= ST_DONE;
                  post_faults_o <= ~req_pre_fault_i;
                end else if (~msr_mapped) begin
                  // RULE14 unmapped always exits
                  hit_ff <= 1'b1;
                  state_ff <= ST_DONE;
                end else begin
                  bitno_ff <= msr_bitno;
                  post_faults_o <= 1'b1;
                  nbytes_ff <= 3'h1;
                  cnt_ff <= 3'h0;
                  state_ff <= ST_FETCH;
                end
                // RULE17 read 0, write 1
                info1_ff <= {31'h0, req_msr_write_i};
              end
              default: begin
                state_ff <= ST_IDLE;
                done_o <= 1'b1;
                // RULE22 debug registers first
                debug_regs_update_o <= (req_vec_i == `IOXC_VEC_DB);
                // RULE20 interrupts bypass
                // RULE21 nested and merged checks
                // RULE23 single-byte debug exempt
                if (~req_is_intr_i & excmask_ff[req_vec_i] &
                    ~((req_vec_i == `IOXC_VEC_DB) & req_single_byte_dbg_i)) begin
                  exit_o <= 1'b1;
                  exit_code_ff <= `IOXC_EXIT_EXC + {7'h0, req_vec_i};
                  pend_ff <= req_merged_i ? prior_ff : `IOXC_RST_WORD;
                  // RULE18 error code
                  info1_ff <= req_has_err_i ? req_err_i : `IOXC_RST_WORD;
                  // RULE19 own pointer for interrupt-based
                  // RULE23 debug fault own, trap next
                  if ((req_vec_i == `IOXC_VEC_BP) | (req_vec_i == `IOXC_VEC_OF) |
                      (req_vec_i == `IOXC_VEC_BR)) begin
                    info2_ff <= req_own_ip_i;
                  end else if (req_vec_i == `IOXC_VEC_DB) begin
                    info2_ff <= req_debug_trap_i ? req_next_ip_i : req_own_ip_i;
                  end else begin
                    info2_ff <= req_frame_ip_i;
                  end
                end else begin
                  post_faults_o <= 1'b1;
                  prior_ff <= {26'h0, 1'b1, req_vec_i};
                end
              end
            endcase
          end
        end
        ST_FETCH: begin
          // RULE1 linear bit array
          // RULE4 bit per port
          mem_req_o <= 1'b1;
          mem_addr_o <= (is_port_ff ? port_base_ff : model_base_ff) +
            {38'h0, bitno_ff[16:3]};
          mem_bit_o <= bitno_ff[2:0];
          state_ff <= ST_WAIT;
        end
        ST_WAIT: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            // RULE5 any byte bit exits
            if (mem_bit_i | (cnt_ff + 3'h1 == nbytes_ff)) begin
              hit_ff <= hit_ff | mem_bit_i;
              state_ff <= ST_DONE;
            end else begin
              cnt_ff <= cnt_ff + 3'h1;
              bitno_ff <= bitno_ff + 17'h1;
              state_ff <= ST_FETCH;
            end
          end
        end
        ST_DONE: begin
          done_o <= 1'b1;
          exit_o <= hit_ff;
          post_faults_o <= post_faults_o & ~hit_ff;
          // RULE10 next pointer saved
          if (hit_ff) begin
            exit_code_ff <= is_port_ff ? `IOXC_EXIT_PORT : `IOXC_EXIT_MODEL;
          end
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // ioxc_intercept
`default_nettype wire

// *** core/ioxc_consts.vh ***
// Constants for the port, model register and exception intercept check.
// Assumes inclusion by the design file and the bench of this block.
`ifndef IOXC_CONSTS_VH
`define IOXC_CONSTS_VH
// Register offsets (word indices on wb_adr_i bits 5:2)
`define IOXC_REG_CTRL 4'h0
`define IOXC_REG_PORT_BASE_LO 4'h1
`define IOXC_REG_PORT_BASE_HI 4'h2
`define IOXC_REG_MODEL_BASE_LO 4'h3
`define IOXC_REG_MODEL_BASE_HI 4'h4
`define IOXC_REG_MAXPA 4'h5
`define IOXC_REG_EXCMASK 4'h6
`define IOXC_REG_STATUS 4'h7
`define IOXC_REG_CODE 4'h8
`define IOXC_REG_INFO1 4'h9
`define IOXC_REG_INFO2_LO 4'ha
`define IOXC_REG_INFO2_HI 4'hb
`define IOXC_REG_PEND 4'hc
// Control bit positions
`define IOXC_CTRL_PORT_EN 0
`define IOXC_CTRL_MODEL_EN 1
`define IOXC_CTRL_LAUNCH 2
// Map sizes (last byte offsets)
`define IOXC_PORT_MAP_LAST 52'h0_0000_0000_2000
`define IOXC_MODEL_MAP_LAST 52'h0_0000_0000_1fff
// Model register map slices
`define IOXC_MSR_HI_MID 19'h6_0000
`define IOXC_MSR_HI_TOP 19'h6_0008
`define IOXC_MAP_OFS_MID 2'h1
`define IOXC_MAP_OFS_TOP 2'h2
// Exit reason codes
`define IOXC_EXIT_PORT 12'h07b
`define IOXC_EXIT_MODEL 12'h07c
`define IOXC_EXIT_EXC 12'h040
`define IOXC_EXIT_INVALID 12'hfff
`define IOXC_EXIT_NONE 12'h000
// Exception vectors of note
`define IOXC_VEC_DB 5'h01
`define IOXC_VEC_BP 5'h03
`define IOXC_VEC_OF 5'h04
`define IOXC_VEC_BR 5'h05
`define IOXC_VEC_DF 5'h08
// Field positions in first exit word
`define IOXC_F_PORT 16
`define IOXC_F_SEG 10
`define IOXC_F_A64 9
`define IOXC_F_OPERAND_DWORD_FLAG 6
`define IOXC_F_REP 3
`define IOXC_F_STR 2
`define IOXC_SEG_EXTRA 3'h0
// Reset values
`define IOXC_RST_WORD 32'h0000_0000
`define IOXC_RST_MAXPA 32'h000f_ffff
`endif

// *** tb/ioxc_mem_model.sv ***
// Bit-addressed permission bitmap memory seen by the intercept block.
// Assumes one bit read at a time; answer LAT+1 cycles after the request.
`timescale 1ns/1ps
`default_nettype none
module ioxc_mem_model #(
  parameter int LAT = 2
) (
  // Clock
  input wire logic clk_i,
  // Bit read request
  input wire logic req_i,
  input wire logic [51:0] addr_i,
  input wire logic [2:0] bit_i,
  // Answer
  output logic ack_o,
  output logic data_o
);
  bit map_q[logic [54:0]];
  int wait_q = 0;
  logic last_q = 1'b0;
  initial begin
    ack_o = 1'b0;
    data_o = 1'b1;
  end
  task automatic set_bit(input logic [51:0] a, input logic [2:0] b);
    map_q[{a, b}] = 1'b1;
  endtask
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    data_o <= ~last_q;
    if (req_i && !ack_o) begin
      wait_q <= wait_q + 1;
      if (wait_q >= LAT) begin
        wait_q <= 0;
        ack_o <= 1'b1;
        data_o <= map_q.exists({addr_i, bit_i}) != 0;
        last_q <= map_q.exists({addr_i, bit_i}) != 0;
      end
    end
  end
endmodule // ioxc_mem_model
`default_nettype wire

// *** tb/ioxc_intercept_chk.sv ***
// Port-level checker of the intercept block.
// Assumes binding to ioxc_intercept, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ioxc_intercept_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic [1:0] req_kind_i,
  input wire logic [15:0] req_port_i,
  input wire logic [31:0] req_msr_i,
  input wire logic req_msr_write_i,
  input wire logic req_pre_fault_i,
  input wire logic [4:0] req_vec_i,
  input wire logic req_is_intr_i,
  input wire logic req_single_byte_dbg_i,
  // Result and memory
  input wire logic done_o,
  input wire logic exit_o,
  input wire logic debug_regs_update_o,
  input wire logic mem_req_o,
  input wire logic [51:0] mem_addr_o,
  input wire logic [2:0] mem_bit_o,
  input wire logic mem_ack_i,
  input wire logic mem_bit_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take, exc, msr_out, wr_ff, first_ff;
  logic [1:0] kind_ff;
  logic [31:0] num_ff;
  assign take = req_valid_i && req_ready_o;
  assign exc = take && req_kind_i == 2'h2;
  assign msr_out = req_msr_i[31:13] != 19'h0 && req_msr_i[31:13] != 19'h6_0000
    && req_msr_i[31:13] != 19'h6_0008;
  // Request held from acceptance
  always @(posedge clk_i) begin
    if (take) begin
      kind_ff <= req_kind_i;
      num_ff <= req_kind_i == 2'h0 ? {16'h0000, req_port_i} : req_msr_i;
      wr_ff <= req_msr_write_i;
    end
    first_ff <= !rst_i && (take || (first_ff && !mem_req_o));
  end
  sequence s_quiet_done;
    ##[1:4] (done_o && !exit_o);
  endsequence
  sequence s_exit_done;
    ##[1:3] (done_o && exit_o);
  endsequence
  chk_intr_bypass: assert property (exc && req_is_intr_i |-> s_quiet_done)
    else $error("interrupt intercepted");
  chk_early_fault: assert property (take && req_kind_i != 2'h2 && req_pre_fault_i
    |-> !mem_req_o throughout s_quiet_done) else $error("early fault not first");
  chk_single_byte_debug_instr_exempt: assert property (exc && req_vec_i == 5'h01 && req_single_byte_dbg_i
    && !req_is_intr_i |-> s_quiet_done) else $error("single byte debug exit");
  chk_debug_update: assert property (exc && req_vec_i == 5'h01 && !req_single_byte_dbg_i
    && !req_is_intr_i |-> ##[1:3] debug_regs_update_o) else $error("no debug update");
  chk_unmapped_msr: assert property (take && req_kind_i == 2'h1 && msr_out
    |-> !mem_req_o throughout ##[1:4] done_o) else $error("unmapped lookup");
  chk_set_bit_exit: assert property (mem_req_o && mem_ack_i && mem_bit_i
    |-> s_exit_done) else $error("set bit no exit");
  chk_msr_bit_index: assert property (mem_req_o && kind_ff == 2'h1
    |-> mem_addr_o[10:0] == num_ff[12:2] && mem_bit_o == {num_ff[1:0], wr_ff})
    else $error("model map index");
  chk_port_bit_index: assert property (mem_req_o && first_ff && kind_ff == 2'h0
    |-> mem_addr_o[11:0] == num_ff[14:3] && mem_bit_o == num_ff[2:0])
    else $error("port map index");
endmodule // ioxc_intercept_chk
bind ioxc_intercept ioxc_intercept_chk chk_u (.*);
`default_nettype wire

// *** tb/ioxc_intercept_tb.sv ***
// Self-checking bench of the intercept block.
// Assumes the bitmap memory model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "ioxc_consts.vh"
module ioxc_intercept_tb;
  typedef struct packed {logic [1:0] k; logic [31:0] n; logic [2:0] sz; logic [6:0] f;} ioxc_row_t;
  ioxc_row_t rows[$];
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [5:2] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q, req_msr_i = '0, req_err_i = 32'h0000_1234;
  logic req_valid_i = 0, req_in_i = 0, req_rep_i = 0, req_str_i = 0, req_msr_write_i = 0;
  logic req_pre_fault_i = 0, req_has_err_i = 0, req_is_intr_i = 0, req_single_byte_dbg_i = 0;
  logic req_debug_trap_i = 0, req_merged_i = 0, req_ready_o, done_o, exit_o, post_faults_o;
  logic debug_regs_update_o, mem_req_o, mem_ack_i, mem_bit_i;
  logic [1:0] req_kind_i = '0;
  logic [15:0] req_port_i = '0;
  logic [2:0] req_size_i = '0, req_addr_width_i = 3'h2, req_seg_i = 3'h3, mem_bit_o;
  logic [4:0] req_vec_i = '0;
  logic [51:0] mem_addr_o;
  logic [63:0] req_next_ip_i = '0, req_own_ip_i = 64'h0000_1000, req_frame_ip_i = 64'h0000_2000;
  logic [35:0] rtab[4] = '{{`IOXC_REG_CTRL, `IOXC_RST_WORD}, {`IOXC_REG_MAXPA, `IOXC_RST_MAXPA},
    {`IOXC_REG_CODE, `IOXC_RST_WORD}, {4'hf, `IOXC_RST_WORD}};
  int num_errors = 0, total_checks = 0, n;
  always #4 clk_i = ~clk_i;
  ioxc_intercept dut_u (.*);
  ioxc_mem_model #(.LAT(2)) mem_u (.clk_i(clk_i), .req_i(mem_req_o), .addr_i(mem_addr_o),
    .bit_i(mem_bit_o), .ack_o(mem_ack_i), .data_o(mem_bit_i));
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic run_req(input ioxc_row_t r);
    @(posedge clk_i);
    {req_kind_i, req_port_i, req_msr_i, req_vec_i, req_size_i} <= {r.k, r.n[15:0], r.n, r.n[4:0], r.sz};
    {req_in_i, req_str_i, req_msr_write_i, req_pre_fault_i} <= r.f[6:3];
    {req_is_intr_i, req_single_byte_dbg_i, req_rep_i} <= {r.f[2:1], r.f[5]};
    req_has_err_i <= r.k == 2'h2 && r.n == 32'h0000_000d;
    req_next_ip_i <= {32'h0000_0012, r.n};
    req_valid_i <= 1'b1;
    do @(posedge clk_i); while (req_ready_o !== 1'b1);
    req_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 60);
    check("done", done_o, 1'b1);
    check("exit", exit_o, r.f[0]);
    check("post", post_faults_o, !r.f[0] && !r.f[3]);
  endtask
  function automatic logic [31:0] exp_info(input ioxc_row_t r);
    if (r.k == 2'h1) return {31'h0, r.f[4]};
    if (r.k == 2'h2) return 32'h0000_1234;
    return {r.n[15:0], 3'h0, r.f[5] && r.f[6] ? 3'h0 : 3'h3, 3'h2, r.sz, r.f[5], r.f[5], 1'b0, r.f[6]};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100_000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, `IOXC_REG_MAXPA, 32'h0000_0000, 4'h7);
    foreach (rtab[i]) begin
      wb(1'b0, rtab[i][35:32], 32'h0000_0000, 4'hf);
      check("reset reg", q, rtab[i][31:0]);
    end
    $display("reset test done");
    wb(1'b1, `IOXC_REG_PORT_BASE_LO, 32'h0004_0abc, 4'hf);
    wb(1'b1, `IOXC_REG_PORT_BASE_HI, 32'h0000_0000, 4'hf);
    wb(1'b1, `IOXC_REG_MODEL_BASE_LO, 32'h0008_0fff, 4'hf);
    wb(1'b1, `IOXC_REG_MODEL_BASE_HI, 32'h0000_0000, 4'hf);
    wb(1'b1, `IOXC_REG_EXCMASK, 32'h0000_2002, 4'hf);
    wb(1'b1, `IOXC_REG_CTRL, 32'h0000_0007, 4'hf);
    wb(1'b0, `IOXC_REG_CODE, 32'h0000_0000, 4'hf);
    check("launch code", q, `IOXC_EXIT_NONE);
    mem_u.set_bit(52'h4_0008, 3'h0);
    mem_u.set_bit(52'h4_2000, 3'h1);
    mem_u.set_bit(52'h8_0004, 3'h0);
    mem_u.set_bit(52'h8_0800, 3'h3);
    rows = '{{2'h0, 32'h0000_0040, 3'h1, 7'h41}, {2'h0, 32'h0000_003e, 3'h4, 7'h21},
      {2'h0, 32'h0000_0041, 3'h2, 7'h00}, {2'h0, 32'h0000_fffe, 3'h4, 7'h41},
      {2'h0, 32'h0000_0040, 3'h1, 7'h61}, {2'h0, 32'h0000_0040, 3'h1, 7'h08},
      {2'h1, 32'h0000_0010, 3'h0, 7'h01}, {2'h1, 32'h0000_0010, 3'h0, 7'h10},
      {2'h1, 32'hc000_0001, 3'h0, 7'h11}, {2'h1, 32'hc001_0003, 3'h0, 7'h00},
      {2'h1, 32'h0000_2000, 3'h0, 7'h01}, {2'h1, 32'hc000_0001, 3'h0, 7'h18},
      {2'h2, 32'h0000_000d, 3'h0, 7'h01}, {2'h2, 32'h0000_000d, 3'h0, 7'h04},
      {2'h2, 32'h0000_0001, 3'h0, 7'h02}, {2'h2, 32'h0000_0001, 3'h0, 7'h01},
      {2'h2, 32'h0000_0005, 3'h0, 7'h00}};
    foreach (rows[i]) begin
      run_req(rows[i]);
      if (rows[i].f[0]) begin
        wb(1'b0, `IOXC_REG_CODE, 32'h0000_0000, 4'hf);
        check("code", q, rows[i].k == 2'h0 ? `IOXC_EXIT_PORT : rows[i].k == 2'h1 ?
          `IOXC_EXIT_MODEL : `IOXC_EXIT_EXC + rows[i].n[4:0]);
        wb(1'b0, `IOXC_REG_INFO1, 32'h0000_0000, 4'hf);
        if (rows[i].k != 2'h2 || rows[i].n == 32'h0000_000d)
          check("info1", q, exp_info(rows[i]));
        if (rows[i].k == 2'h0) begin
          wb(1'b0, `IOXC_REG_INFO2_LO, 32'h0000_0000, 4'hf);
          check("info2 lo", q, rows[i].n);
          wb(1'b0, `IOXC_REG_INFO2_HI, 32'h0000_0000, 4'hf);
          check("info2 hi", q, 32'h0000_0012);
        end
      end
      $display("row %0d done", i);
    end
    wb(1'b1, `IOXC_REG_CTRL, 32'h0000_0000, 4'hf);
    run_req({2'h1, 32'h0000_0010, 3'h0, 7'h00});
    $display("disable test done");
    wb(1'b1, `IOXC_REG_MAXPA, 32'h0000_0000, 4'hf);
    wb(1'b1, `IOXC_REG_CTRL, 32'h0000_0004, 4'hf);
    wb(1'b0, `IOXC_REG_CODE, 32'h0000_0000, 4'hf);
    check("invalid code", q, `IOXC_EXIT_INVALID);
    $display("invalid test done");
    print_verdict();
  end
endmodule // ioxc_intercept_tb
`default_nettype wire
